// ---- hdl/ossu_ctrl_map.vh ----
`ifndef OSSU_CTRL_MAP_VH
`define OSSU_CTRL_MAP_VH
// Clock rate in kHz (200 MHz)
`define OSSU_CLK_KHZ 200000
// Nominal switching frequencies, kHz
`define OSSU_FSW_LO_KHZ 65
`define OSSU_FSW_HI_KHZ 100
// Maximum on times, ns
`define OSSU_TON_LO_NS 12300
`define OSSU_TON_HI_NS 8000
// Jitter: +/-6 percent, 125 Hz triangle
`define OSSU_JIT_PCT 6
`define OSSU_JIT_HZ 125
// Line sample period, us, and detection timer, us
`define OSSU_TSAMPLE_US 1000
`define OSSU_TDET_US 32000
// Go-to-off qualify time, us
`define OSSU_TQUAL_US 1000
// Detector offset in sense codes
`define OSSU_DET_OFFSET 12'h010
// Feedback thresholds in mV
`define OSSU_FEED_OFF_MV 400
`define OSSU_FEED_ON_MV 2200
`endif

// ---- hdl/ossu_ctrl.v ----
// Summary of operation
// - Start source on above line minimum, off at start level, on at recharge.
// - First switching only at start level with positive line slope.
// - Supply overvoltage latches device off, no drive pulses.
// - Below short guard level, start-up current is reduced.
// - Source turns on at recharge level unless line below minimum.
// - Restart after drop-out needs start level and positive slope.
// - Detected X2 discharge need drives source at discharge current.
// - Live line sample compared to held sample taken each period.
// - No hysteresis; offset added to held sample; crossing resets timer.
// - Any comparator edge restarts timer; expiry flags dc/unplug.
// - Comparator pulses only for positive slopes above resolution.
// - X2 discharge works in every mode, fault and off included.
// - Detection timer limits discharge phases; repeat until ac or low line.
// - Self-supply keeps supply above stop level during discharge.
// - Feedback below 0.4 V requests off mode.
// - Off mode drops internal rail; self-supply holds regulation level.
// - Leave off mode when feedback rises above 2.2 V, or to latch on supply overvoltage.
// - In off mode only discharge and self-supply operate.
// - Fault latch kept in off mode; thermal shutdown uses off mode.
// - Go-to-off timer qualifies off entry against brief drops.
// - Switching at 65 kHz or 100 kHz by version option.
// - Drive pulse ends at max on time, 12.3 us or 8 us.
`timescale 1ns/1ps
`default_nettype none
`include "ossu_ctrl_map.vh"
module ossu_ctrl #(
    parameter HI_FREQ = 0,
    parameter [23:0] SAMPLE_CYC = 24'd200000,
    parameter [23:0] DET_CYC = 24'd6400000,
    parameter [23:0] QUAL_CYC = 24'd200000
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Supply comparators
    input wire supply_start_level_i,
    input wire supply_recharge_level_i,
    input wire supply_overvoltage_level_i,
    input wire supply_short_guard_level_i,
    input wire supply_stop_level_i,
    input wire supply_offmode_regulation_level_i,
    // Line sense
    input wire line_sense_min_level_i,
    input wire [11:0] line_sense_input_i,
    // Feedback comparators, PWM stop and thermal shutdown
    input wire feedback_below_off_i,
    input wire feedback_above_on_i,
    input wire pwm_stop_i,
    input wire thermal_shutdown_i,
    // Outputs
    output reg startup_src_on_o,
    output reg startup_src_low_o,
    output reg discharge_current_o,
    output reg internal_rail_on_o,
    output reg gate_drive_output_o,
    output reg fault_latched_o,
    output reg off_mode_o,
    output reg dc_detect_o
);
    localparam [23:0] SMP = SAMPLE_CYC;
    localparam integer TON_NS = HI_FREQ ? `OSSU_TON_HI_NS : `OSSU_TON_LO_NS;
    localparam integer FSW = HI_FREQ ? `OSSU_FSW_HI_KHZ : `OSSU_FSW_LO_KHZ;
    localparam integer PER_I = `OSSU_CLK_KHZ / FSW;
    localparam integer TON_I = (TON_NS * 2) / 10;
    localparam integer JIT_I = (PER_I * `OSSU_JIT_PCT) / 100;
    localparam integer JSTEP_I = (`OSSU_CLK_KHZ * 1000) / (`OSSU_JIT_HZ * 4);
    localparam [15:0] PERIOD = PER_I[15:0];
    localparam [15:0] TON_MAX = TON_I[15:0];
    localparam [15:0] JIT = JIT_I[15:0];
    localparam [23:0] JSTEP = JSTEP_I[23:0];
    localparam [1:0] ST_OFF = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;
    localparam [1:0] ST_LATCH = 2'h3;

    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Two-stage input synchronisers
    localparam integer NB = 12;
    wire [NB-1:0] raw = {supply_start_level_i, supply_recharge_level_i,
        supply_overvoltage_level_i, supply_short_guard_level_i,
        supply_stop_level_i, supply_offmode_regulation_level_i,
        line_sense_min_level_i, feedback_below_off_i, feedback_above_on_i,
        pwm_stop_i, thermal_shutdown_i, 1'b0};
    reg [NB-1:0] s1_reg;
    reg [NB-1:0] s2_reg;
    reg [11:0] l1_reg;
    reg [11:0] l2_reg;
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi = gi + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                end
            end
        end
    endgenerate
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            l1_reg <= 12'h000;
            l2_reg <= 12'h000;
        end else begin
            l1_reg <= line_sense_input_i;
            l2_reg <= l1_reg;
        end
    end
    wire vcc_on = s2_reg[11];
    wire vcc_min = s2_reg[10];
    wire vcc_ovp = s2_reg[9];
    wire vcc_guard = s2_reg[8];
    wire vcc_stop = s2_reg[7];
    wire vcc_reg = s2_reg[6];
    wire line_ok = s2_reg[5];
    wire feed_low = s2_reg[4];
    wire feed_high = s2_reg[3];
    wire pwm_stop = s2_reg[2];
    wire therm = s2_reg[1];

    // Line unplug detector
    reg [23:0] smp_cnt_reg;
    reg [12:0] held_reg;
    reg above_reg;
    reg [23:0] det_cnt_reg;
    reg dc_reg;
    reg dis_reg;
    reg pos_slope_reg;
    wire above_now = ({1'b0, l2_reg} > held_reg);
    wire above_edge = above_now ^ above_reg;
    wire det_exp = (det_cnt_reg == DET_CYC - 24'd1);
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt_reg <= 24'h000000;
            held_reg <= 13'h1FFF;
            above_reg <= 1'b0;
            det_cnt_reg <= 24'h000000;
            dc_reg <= 1'b0;
            dis_reg <= 1'b0;
            pos_slope_reg <= 1'b0;
        end else begin
            if (smp_cnt_reg == SMP - 24'd1) begin
                smp_cnt_reg <= 24'h000000;
                held_reg <= {1'b0, l2_reg} + {1'b0, `OSSU_DET_OFFSET};
            end else begin
                smp_cnt_reg <= smp_cnt_reg + 24'd1;
            end
            above_reg <= above_now;
            if (above_edge) begin
                det_cnt_reg <= 24'h000000;
            end else if (det_exp) begin
                det_cnt_reg <= 24'h000000;
            end else begin
                det_cnt_reg <= det_cnt_reg + 24'd1;
            end
            if (above_now && !above_reg) begin
                pos_slope_reg <= 1'b1;
            end else if (det_exp) begin
                pos_slope_reg <= 1'b0;
            end
            if (above_edge || !line_ok) begin
                dc_reg <= 1'b0;
                dis_reg <= 1'b0;
            end else if (det_exp) begin
                dc_reg <= 1'b1;
                dis_reg <= ~dis_reg;
            end
        end
    end

    // Mode control
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg fault_reg;
    reg [23:0] qual_cnt_reg;
    // Off entry allowed from every awake state, latched too
    wire awake = (st_reg != ST_OFF);
    wire qual_exp = (qual_cnt_reg == QUAL_CYC - 24'd1);
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            qual_cnt_reg <= 24'h000000;
        end else if (feed_low && awake && !qual_exp) begin
            qual_cnt_reg <= qual_cnt_reg + 24'd1;
        end else if (!feed_low) begin
            qual_cnt_reg <= 24'h000000;
        end
    end
    always @* begin
        st_next = st_reg;
        case (st_reg)
            ST_OFF: begin
                if (feed_high && !therm) begin
                    st_next = fault_reg ? ST_LATCH : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (vcc_on && pos_slope_reg) begin
                    st_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!vcc_stop) begin
                    st_next = ST_WAIT;
                end
            end
            default: begin
                st_next = ST_LATCH;
            end
        endcase
        if (vcc_ovp) begin
            st_next = ST_LATCH;
        end
        if (qual_exp && awake) begin
            st_next = ST_OFF;
        end
        if (therm) begin
            st_next = ST_OFF;
        end
    end
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_OFF;
            fault_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (vcc_ovp) begin
                fault_reg <= 1'b1;
            end
        end
    end

    // Start-up source sequencing
    reg src_reg;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= 1'b0;
        end else if (!line_ok) begin
            src_reg <= 1'b0;
        end else if (st_reg == ST_OFF) begin
            src_reg <= !vcc_reg;
        end else if (vcc_on) begin
            src_reg <= 1'b0;
        end else if (!vcc_min) begin
            src_reg <= 1'b1;
        end
    end

    // Oscillator with jitter
    reg [15:0] osc_cnt_reg;
    reg [15:0] jit_reg;
    reg jit_up_reg;
    reg [23:0] jstep_cnt_reg;
    reg gate_reg;
    wire [15:0] per_now = PERIOD - JIT + jit_reg;
    // on time bounded to 80 percent
    wire ton_end = (osc_cnt_reg >= TON_MAX - 16'd1);
    wire run = (st_reg == ST_RUN);
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_reg <= 16'h0000;
            jit_reg <= 16'h0000;
            jit_up_reg <= 1'b1;
            jstep_cnt_reg <= 24'h000000;
            gate_reg <= 1'b0;
        end else begin
            if (jstep_cnt_reg == JSTEP / {8'h00, JIT}) begin
                jstep_cnt_reg <= 24'h000000;
                if (jit_up_reg) begin
                    if (jit_reg >= JIT + JIT - 16'd1) begin
                        jit_up_reg <= 1'b0;
                    end
                    jit_reg <= jit_reg + 16'd1;
                end else begin
                    if (jit_reg <= 16'd1) begin
                        jit_up_reg <= 1'b1;
                    end
                    jit_reg <= jit_reg - 16'd1;
                end
            end else begin
                jstep_cnt_reg <= jstep_cnt_reg + 24'd1;
            end
            if (osc_cnt_reg >= per_now - 16'd1) begin
                osc_cnt_reg <= 16'h0000;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 16'd1;
            end
            if (!run) begin
                gate_reg <= 1'b0;
            end else if (osc_cnt_reg >= per_now - 16'd1) begin
                gate_reg <= 1'b1;
            end else if (ton_end || pwm_stop) begin
                gate_reg <= 1'b0;
            end
        end
    end

    // Registered outputs
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            startup_src_on_o <= 1'b0;
            startup_src_low_o <= 1'b0;
            discharge_current_o <= 1'b0;
            internal_rail_on_o <= 1'b0;
            gate_drive_output_o <= 1'b0;
            fault_latched_o <= 1'b0;
            off_mode_o <= 1'b1;
            dc_detect_o <= 1'b0;
        end else begin
            startup_src_on_o <= src_reg || dis_reg;
            discharge_current_o <= dis_reg;
            startup_src_low_o <= !vcc_guard;
            internal_rail_on_o <= (st_reg != ST_OFF);
            gate_drive_output_o <= gate_reg;
            fault_latched_o <= fault_reg;
            off_mode_o <= (st_reg == ST_OFF);
            dc_detect_o <= dc_reg;
        end
    end
endmodule
`default_nettype wire

// ---- verif/ossu_ctrl_env.sv ----
`timescale 1ns/1ps
`default_nettype none
module ossu_ctrl_env (
    // Control
    input wire logic clk_i,
    input wire logic src_on_i,
    input wire logic [1:0] mode_i,
    // Line and supply
    output logic line_min_o,
    output logic [11:0] line_o,
    output logic [4:0] sup_o
);
    logic dn_reg = 1'b0;
    int v_reg = 0;
    initial line_o = 12'h200;
    // Mode 0 ac ramp, 1 dc hold, 2 line gone
    always @(negedge clk_i) begin
        if (mode_i == 2'h0)
            line_o <= dn_reg ? line_o - 12'h004 : line_o + 12'h004;
        if (mode_i == 2'h2)
            line_o <= 12'h000;
        dn_reg <= (line_o > 12'h5F8) | (dn_reg & (line_o > 12'h208));
        if (src_on_i && v_reg < 70)
            v_reg <= v_reg + 1;
        else if (!src_on_i && v_reg > 0)
            v_reg <= v_reg - 1;
    end
    assign line_min_o = (mode_i != 2'h2);
    assign sup_o = {v_reg > 59, v_reg > 30, v_reg > 15, v_reg > 20, v_reg > 40};
endmodule
`default_nettype wire

// ---- verif/ossu_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ossu_ctrl_sva #(
    parameter HI_FREQ = 0,
    parameter [23:0] QUAL_CYC = 24'd200000
) (
    // Clock, reset, inputs
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_overvoltage_level_i,
    input wire logic line_sense_min_level_i,
    input wire logic feedback_below_off_i,
    input wire logic thermal_shutdown_i,
    // Outputs
    input wire logic startup_src_on_o,
    input wire logic discharge_current_o,
    input wire logic gate_drive_output_o,
    input wire logic fault_latched_o,
    input wire logic off_mode_o
);
    localparam int TON = HI_FREQ ? 1600 : 2460;
    localparam int TMIN = HI_FREQ ? 1878 : 2889;
    int on_cnt, gap_cnt, low_cnt;
    logic therm_seen;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_cnt <= 0;
            gap_cnt <= TMIN;
            low_cnt <= 0;
            therm_seen <= 1'b0;
        end else begin
            on_cnt <= gate_drive_output_o ? on_cnt + 1 : 0;
            gap_cnt <= (gate_drive_output_o && on_cnt == 0) ? 1 : gap_cnt + 1;
            low_cnt <= feedback_below_off_i ? low_cnt + 1 : 0;
            therm_seen <= therm_seen | thermal_shutdown_i;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence ovp_held;
        supply_overvoltage_level_i [*4];
    endsequence
    sequence line_gone;
        !line_sense_min_level_i [*8];
    endsequence
    drive_off_mode_a: assert property (off_mode_o [*2] |-> !gate_drive_output_o)
        else $error("drive in off mode");
    fault_no_drive_a: assert property (fault_latched_o [*2] |-> !gate_drive_output_o)
        else $error("drive while latched");
    fault_kept_a: assert property (fault_latched_o |=> fault_latched_o)
        else $error("fault latch lost");
    ovp_latch_a: assert property (ovp_held |-> ##[0:4] fault_latched_o)
        else $error("overvoltage not latched");
    max_on_a: assert property (gate_drive_output_o |-> on_cnt <= TON)
        else $error("on time too long");
    min_period_a: assert property ($rose(gate_drive_output_o) |-> gap_cnt >= TMIN)
        else $error("period too short");
    off_entry_a: assert property ($rose(off_mode_o) |-> therm_seen || low_cnt >= QUAL_CYC)
        else $error("off entry not qualified");
    line_low_a: assert property (line_gone |-> !startup_src_on_o && !discharge_current_o)
        else $error("source on with line low");
endmodule
bind ossu_ctrl ossu_ctrl_sva #(.HI_FREQ(HI_FREQ), .QUAL_CYC(QUAL_CYC)) u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .supply_overvoltage_level_i(supply_overvoltage_level_i),
    .line_sense_min_level_i(line_sense_min_level_i),
    .feedback_below_off_i(feedback_below_off_i),
    .thermal_shutdown_i(thermal_shutdown_i),
    .startup_src_on_o(startup_src_on_o),
    .discharge_current_o(discharge_current_o),
    .gate_drive_output_o(gate_drive_output_o),
    .fault_latched_o(fault_latched_o), .off_mode_o(off_mode_o));
`default_nettype wire

// ---- verif/ossu_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ossu_ctrl_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ovp = 1'b0, feed_lo = 1'b0, feed_hi = 1'b0, pstop = 1'b0;
    logic therm = 1'b0;
    logic [1:0] mode = 2'h0;
    logic line_min, src_on, src_low, dis, rail, gate, fault, off, dc;
    logic [11:0] line;
    logic [4:0] sup;
    logic [6:0] outs;
    int failures = 0, n_checks = 0, hi, per, k;
    int seed = 32'h94DC0677;
    assign outs = {src_low, src_on, dc, dis, off, fault, gate};
    initial forever #2.5 clk_i = ~clk_i;
    ossu_ctrl #(.HI_FREQ(0), .SAMPLE_CYC(24'd50), .DET_CYC(24'd400),
        .QUAL_CYC(24'd100)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .supply_start_level_i(sup[4]), .supply_recharge_level_i(sup[3]),
        .supply_overvoltage_level_i(ovp), .supply_short_guard_level_i(sup[2]),
        .supply_stop_level_i(sup[1]),
        .supply_offmode_regulation_level_i(sup[0]),
        .line_sense_min_level_i(line_min), .line_sense_input_i(line),
        .feedback_below_off_i(feed_lo), .feedback_above_on_i(feed_hi),
        .pwm_stop_i(pstop), .thermal_shutdown_i(therm),
        .startup_src_on_o(src_on), .startup_src_low_o(src_low),
        .discharge_current_o(dis), .internal_rail_on_o(rail),
        .gate_drive_output_o(gate), .fault_latched_o(fault),
        .off_mode_o(off), .dc_detect_o(dc));
    ossu_ctrl_env env (.clk_i(clk_i), .src_on_i(src_on), .mode_i(mode),
        .line_min_o(line_min), .line_o(line), .sup_o(sup));
    function automatic int cyc(input int ns);
        return ns / 5;
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_out(string what, int i, logic v, int lim);
        int n;
        n = 0;
        while (outs[i] !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        check(what, outs[i], v);
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    initial begin
        hold(80000);
        failures++;
        end_sim();
    end
    initial begin
        hold(12);
        check("reset mode", off, 1'b1);
        rst_n_i = 1'b1;
        wait_out("src low", 6, 1'b1, 12);
        feed_hi = 1'b1;
        wait_out("wake", 2, 1'b0, 60);
        feed_hi = 1'b0;
        wait_out("first run", 0, 1'b1, 9000);
        for (int i = 0; i < 2; i++) begin
            hi = 0;
            while (gate === 1'b1 && hi < 4000) begin
                hold(1);
                hi++;
            end
            per = hi;
            while (gate !== 1'b1 && per < 4000) begin
                hold(1);
                per++;
            end
        end
        check("on time", hi inside {[cyc(12300) - 2:cyc(12300)]}, 1);
        k = cyc(15384);
        check("period", per inside {[k * 94 / 100 - 2:k * 106 / 100 + 2]}, 1);
        repeat (3) begin
            k = 100 + $unsigned($random(seed)) % 2000;
            wait_out("rise", 0, 1'b1, 4000);
            hold(k);
            pstop = 1'b1;
            wait_out("pwm stop", 0, 1'b0, 6);
            pstop = 1'b0;
        end
        repeat (8) begin
            feed_lo = 1'b1;
            hold(1 + $unsigned($random(seed)) % 60);
            feed_lo = 1'b0;
            hold(40);
            check("glitch", off, 1'b0);
        end
        feed_lo = 1'b1;
        wait_out("off entry", 2, 1'b1, 120);
        hold(2);
        check("off drive", gate, 1'b0);
        check("off rail", rail, 1'b0);
        mode = 2'h1;
        wait_out("dc seen", 4, 1'b1, 1500);
        wait_out("discharge", 3, 1'b1, 1500);
        hold(2);
        check("disch source", src_on, 1'b1);
        mode = 2'h0;
        wait_out("ac back", 4, 1'b0, 1200);
        check("disch end", dis, 1'b0);
        mode = 2'h1;
        wait_out("disch again", 3, 1'b1, 1500);
        mode = 2'h2;
        wait_out("line low", 3, 1'b0, 12);
        hold(12);
        check("src line low", src_on, 1'b0);
        mode = 2'h0;
        feed_lo = 1'b0;
        feed_hi = 1'b1;
        wait_out("rewake", 2, 1'b0, 60);
        feed_hi = 1'b0;
        wait_out("restart", 0, 1'b1, 9000);
        therm = 1'b1;
        wait_out("thermal off", 2, 1'b1, 12);
        therm = 1'b0;
        feed_hi = 1'b1;
        wait_out("wake 3", 2, 1'b0, 60);
        feed_hi = 1'b0;
        wait_out("run 3", 0, 1'b1, 9000);
        ovp = 1'b1;
        wait_out("ovp latch", 1, 1'b1, 12);
        ovp = 1'b0;
        feed_lo = 1'b1;
        wait_out("off latched", 2, 1'b1, 120);
        feed_lo = 1'b0;
        feed_hi = 1'b1;
        hold(300);
        check("latch kept", fault, 1'b1);
        check("latch drive", gate, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
